// File: rtl/sgds_top.v
/*
  sine test and reference generator with dual-slope conversion sequencer,
  registers on apb.
  assumes pclk is the single crystal-derived time base, comparator flags are
  asynchronous active-low pins, and the host polls status over apb.
*/
// The APB interface to the registers and the register addresses were chosen for this implementation.
// How it works
// - 6-bit divider clocked at 64f; its bits are the 32f down to f waves.
// - divider addresses 64-step sine table; 8-bit word drives test dac.
// - filter select output follows the programmed test frequency.
// - reference table on same address; 90/180/270 shift by adding the phase to the top two bits.
// - reference words drive the multiplying dac digital inputs.
// - after integration, deintegrate until zero-cross comparator reports zero.
// - counter runs only during deintegration; final count readable as result.
// - overrange starts deintegration early while sampling runs to its end.
// - wait for start, settling delay, previous cycle end and count clock.
// - sync wait at most one period, or 1/32 period at low frequency.
// - fast rate integrates whole periods nearest 4 ms times factor.
// - medium rate integrates most whole periods not over 16.7 ms times factor.
// - slow rate integrates most whole periods not over 100 ms.
// - factor defaults to 10, host may program 0.25 to 6.
// - fast and medium take six cycles, two each at 0, 90, 180.
// - quick acquisition in fast or medium takes five cycles.
// - slow takes eight cycles, two each at 0, 90, 180, 270.
// - all timing derives from pclk so test and reference stay locked.
`timescale 1ns/1ps
`default_nettype none
`include "sgds_consts.vh"
module sgds_top (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // comparators, active low
  input  wire        zero_cross_flag_n,
  input  wire        integ_overrange_flag_n,
  // analog side
  output reg  [7:0]  test_dac,
  output reg  [7:0]  ref_dac,
  output reg  [1:0]  filter_sel,
  output reg  [5:0]  freq_bits,
  output reg         freq_count_clock,
  output reg         integ_sample,
  output reg         integ_deint
);
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_DELAY = 3'h1;
  localparam [2:0] ST_SYNC  = 3'h2;
  localparam [2:0] ST_INTEG = 3'h3;
  localparam [2:0] ST_DEINT = 3'h4;
  localparam [2:0] ST_TAIL  = 3'h5;

  localparam [39:0] CYC_FAST = `SGDS_T_FAST_US * `SGDS_CLK_MHZ;
  localparam [39:0] CYC_MED  = `SGDS_T_MED_US * `SGDS_CLK_MHZ;
  localparam [39:0] CYC_SLOW = `SGDS_T_SLOW_US * `SGDS_CLK_MHZ;

  reg  [23:0] freq_div;
  reg  [7:0]  factor;
  reg  [31:0] delay_ticks;
  reg  [1:0]  rate;
  reg         quick;
  reg         ph_ovr;
  reg  [1:0]  ph_host;
  reg  [23:0] tick_cnt;
  reg         tick;
  reg  [5:0]  div;
  reg  [2:0]  seq_state;
  reg  [3:0]  cyc_idx;
  reg  [1:0]  ph_seq;
  reg  [31:0] wait_cnt;
  reg  [19:0] periods_left;
  reg  [19:0] integ_periods;
  reg  [31:0] meas_cnt;
  reg  [31:0] result;
  reg         result_new;
  reg         acq_done;
  reg         busy;
  reg         start_req;
  reg  [2:0]  zc_sync;
  reg  [2:0]  ov_sync;
  reg         zc_low;
  reg         ov_low;
  wire [7:0]  test_word;
  wire [7:0]  ref_word;
  wire [1:0]  ph_now;
  wire [5:0]  ref_addr;
  wire        wr_en;
  wire        rd_en;

  // whole periods for a budget: nearest or floor; period = 64 ticks of freq_div
  // 20 bits hold the slow budget even at the fastest divider setting
  function [19:0] periods_for;
    input [39:0] budget;
    input [23:0] fdiv;
    input        nearest;
    reg   [39:0] per;
    reg   [39:0] q;
    begin
      per = {10'h000, fdiv, 6'h00};
      q   = nearest ? (budget + {1'b0, per[39:1]}) / per : budget / per;
      if (q == 40'h0)
        q = 40'h1;
      periods_for = (q > 40'h00000FFFFF) ? 20'hFFFFF : q[19:0];
    end
  endfunction

  // fast and medium budgets scaled by factor in quarters; slow budget unscaled
  function [19:0] integ_len;
    input [1:0]  r;
    input [7:0]  f;
    input [23:0] fdiv;
    begin
      case (r)
        `SGDS_RATE_FAST: integ_len = periods_for((CYC_FAST * f) >> 2, fdiv, 1'b1);
        `SGDS_RATE_MED:  integ_len = periods_for((CYC_MED * f) >> 2, fdiv, 1'b0);
        default:         integ_len = periods_for(CYC_SLOW, fdiv, 1'b0);
      endcase
    end
  endfunction

  assign ph_now   = ph_ovr ? ph_host : ph_seq;
  // adding keeps every step a true quarter period; a plain xor would not
  assign ref_addr = {div[5:4] + ph_now, div[3:0]};
  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & penable & ~pwrite;

  sgds_sine_rom u_test_rom (
    .addr (div),
    .data (test_word)
  );

  sgds_sine_rom u_ref_rom (
    .addr (ref_addr),
    .data (ref_word)
  );

  // comparator pins: three stages, change accepted when last two agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zc_sync <= 3'h7;
      ov_sync <= 3'h7;
      zc_low  <= 1'b0;
      ov_low  <= 1'b0;
    end else begin
      zc_sync <= {zc_sync[1:0], zero_cross_flag_n};
      ov_sync <= {ov_sync[1:0], integ_overrange_flag_n};
      if (zc_sync[2] == zc_sync[1])
        zc_low <= ~zc_sync[2];
      if (ov_sync[2] == ov_sync[1])
        ov_low <= ~ov_sync[2];
    end
  end

  // 64f tick and divider, all from pclk
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 24'h000000;
      tick     <= 1'b0;
      div      <= 6'h00;
    end else begin
      tick <= 1'b0;
      if (tick_cnt + 24'h000001 >= freq_div) begin
        tick_cnt <= 24'h000000;
        tick     <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 24'h000001;
      end
      if (tick)
        div <= div + 6'h01;
    end
  end

  // analog outputs registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_dac         <= 8'h80;
      ref_dac          <= 8'h80;
      freq_bits        <= 6'h00;
      freq_count_clock <= 1'b0;
      filter_sel       <= 2'h0;
    end else begin
      test_dac         <= test_word;
      ref_dac          <= ref_word;
      freq_bits        <= div;
      freq_count_clock <= div[5];
      if (freq_div < `SGDS_FILT_T1)
        filter_sel <= 2'h0;
      else if (freq_div < `SGDS_FILT_T2)
        filter_sel <= 2'h1;
      else if (freq_div < `SGDS_FILT_T3)
        filter_sel <= 2'h2;
      else
        filter_sel <= 2'h3;
    end
  end

  // apb register file, zero wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_div    <= `SGDS_FREQ_RST;
      factor      <= `SGDS_FACTOR_RST;
      delay_ticks <= 32'h00000000;
      rate        <= `SGDS_RATE_SLOW;
      quick       <= 1'b0;
      ph_ovr      <= 1'b0;
      ph_host     <= 2'h0;
      start_req   <= 1'b0;
      prdata      <= 32'h00000000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end else begin
      pready    <= psel & ~penable;
      pslverr   <= 1'b0;
      start_req <= 1'b0;
      if (psel & ~penable) begin
        case (paddr)
          `SGDS_OFF_CTRL:   prdata <= {25'h0, ph_host, ph_ovr, rate, quick, 1'b0};
          `SGDS_OFF_FREQ:   prdata <= {8'h00, freq_div};
          `SGDS_OFF_FACTOR: prdata <= {24'h000000, factor};
          `SGDS_OFF_DELAY:  prdata <= delay_ticks;
          `SGDS_OFF_STATUS: prdata <= {24'h0, cyc_idx, acq_done, result_new, busy, 1'b0};
          `SGDS_OFF_RESULT: prdata <= result;
          `SGDS_OFF_INTEG:  prdata <= {12'h000, integ_periods};
          `SGDS_OFF_CYCLE:  prdata <= {29'h0, seq_state};
          default: begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
      // a write lands on the access edge, where the master samples pready
      if (wr_en && pready) begin
        case (paddr)
          `SGDS_OFF_CTRL: begin
            start_req <= pwdata[`SGDS_CTRL_START];
            quick     <= pwdata[`SGDS_CTRL_QUICK];
            rate      <= pwdata[`SGDS_CTRL_RATE_HI:`SGDS_CTRL_RATE_LO];
            ph_ovr    <= pwdata[`SGDS_CTRL_PHOVR];
            ph_host   <= pwdata[`SGDS_CTRL_PHASE_HI:`SGDS_CTRL_PHASE_LO];
          end
          `SGDS_OFF_FREQ:
            freq_div <= (pwdata[23:0] == 24'h0) ? 24'h000001 : pwdata[23:0];
          `SGDS_OFF_FACTOR: begin
            if (pwdata[7:0] < `SGDS_FACTOR_MIN)
              factor <= `SGDS_FACTOR_MIN;
            else if (pwdata[7:0] > `SGDS_FACTOR_MAX)
              factor <= `SGDS_FACTOR_MAX;
            else
              factor <= pwdata[7:0];
          end
          `SGDS_OFF_DELAY:  delay_ticks <= pwdata;
          default: ;
        endcase
      end
    end
  end

  // conversion sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_state     <= ST_IDLE;
      cyc_idx       <= 4'h0;
      ph_seq        <= 2'h0;
      wait_cnt      <= 32'h00000000;
      periods_left  <= 20'h00000;
      integ_periods <= 20'h00000;
      meas_cnt      <= 32'h00000000;
      result        <= 32'h00000000;
      result_new    <= 1'b0;
      acq_done      <= 1'b0;
      busy          <= 1'b0;
      integ_sample  <= 1'b0;
      integ_deint   <= 1'b0;
    end else begin
      // a new result outranks a read clearing the flag
      if (rd_en && paddr == `SGDS_OFF_RESULT)
        result_new <= 1'b0;
      if (start_req)
        acq_done <= 1'b0;
      case (seq_state)
        ST_IDLE: begin
          if (start_req) begin
            busy          <= 1'b1;
            cyc_idx       <= 4'h0;
            ph_seq        <= 2'h0;
            integ_periods <= integ_len(rate, factor, freq_div);
            wait_cnt      <= delay_ticks;
            seq_state     <= ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (wait_cnt == 32'h00000000)
            seq_state <= ST_SYNC;
          else if (tick)
            wait_cnt <= wait_cnt - 32'h00000001;
        end
        ST_SYNC: begin
          // align to period start, or to a 32f boundary (1/32 period) at low f
          if (tick && (div == 6'h3F ||
              (freq_div >= `SGDS_LOWF_TICKS && div[0] == 1'b1))) begin
            periods_left <= integ_periods;
            integ_sample <= 1'b1;
            seq_state    <= ST_INTEG;
          end
        end
        ST_INTEG: begin
          if (integ_deint)
            meas_cnt <= meas_cnt + 32'h00000001;
          else if (ov_low) begin
            integ_deint <= 1'b1;
            meas_cnt    <= 32'h00000000;
          end
          if (tick && div == 6'h3F) begin
            if (periods_left <= 20'h00001) begin
              integ_sample <= 1'b0;
              if (!integ_deint) begin
                integ_deint <= 1'b1;
                meas_cnt    <= 32'h00000000;
              end
              seq_state <= ST_DEINT;
            end else begin
              periods_left <= periods_left - 20'h00001;
            end
          end
        end
        ST_DEINT: begin
          if (zc_low) begin
            integ_deint <= 1'b0;
            result      <= meas_cnt;
            result_new  <= 1'b1;
            seq_state   <= ST_TAIL;
          end else begin
            meas_cnt <= meas_cnt + 32'h00000001;
          end
        end
        ST_TAIL: begin
          if ((rate == `SGDS_RATE_SLOW && cyc_idx == 4'h7) ||
              (rate != `SGDS_RATE_SLOW && quick && cyc_idx == 4'h4) ||
              (rate != `SGDS_RATE_SLOW && !quick && cyc_idx == 4'h5)) begin
            busy      <= 1'b0;
            acq_done  <= 1'b1;
            ph_seq    <= 2'h0;
            seq_state <= ST_IDLE;
          end else begin
            cyc_idx   <= cyc_idx + 4'h1;
            ph_seq    <= next_phase(cyc_idx + 4'h1);
            wait_cnt  <= 32'h00000000;
            seq_state <= ST_SYNC;
          end
        end
        default: seq_state <= ST_IDLE;
      endcase
    end
  end

  // two cycles per phase: 0,0,90,90,180,180,270,270
  function [1:0] next_phase;
    input [3:0] idx;
    begin
      next_phase = idx[2:1];
    end
  endfunction
endmodule // sgds_top
`default_nettype wire

// File: rtl/sgds_consts.vh
/*
  constants for the sine generator and dual-slope sequencer: register offsets,
  field positions, reset values and timing figures.
  assumes inclusion by bare name from the design files.
*/
`ifndef SGDS_CONSTS_VH
`define SGDS_CONSTS_VH

// register byte offsets (apb, one word each)
`define SGDS_OFF_CTRL      12'h000
`define SGDS_OFF_FREQ      12'h004
`define SGDS_OFF_FACTOR    12'h008
`define SGDS_OFF_DELAY     12'h00C
`define SGDS_OFF_STATUS    12'h010
`define SGDS_OFF_RESULT    12'h014
`define SGDS_OFF_INTEG     12'h018
`define SGDS_OFF_CYCLE     12'h01C

// ctrl fields
`define SGDS_CTRL_START    0
`define SGDS_CTRL_QUICK    1
`define SGDS_CTRL_RATE_LO  2
`define SGDS_CTRL_RATE_HI  3
`define SGDS_CTRL_PHOVR    4
`define SGDS_CTRL_PHASE_LO 5
`define SGDS_CTRL_PHASE_HI 6

// rates
`define SGDS_RATE_FAST     2'h0
`define SGDS_RATE_MED      2'h1
`define SGDS_RATE_SLOW     2'h2

// integration-time factor in quarters: default 10, programmable 0.25 .. 6
`define SGDS_FACTOR_RST    8'h28
`define SGDS_FACTOR_MIN    8'h01
`define SGDS_FACTOR_MAX    8'h18

// base integration times in microseconds, pclk rate in MHz
// sized to 40 bits so that budget products need no padding
`define SGDS_T_FAST_US     40'h0000000FA0
`define SGDS_T_MED_US      40'h000000413C
`define SGDS_T_SLOW_US     40'h00000186A0
`define SGDS_CLK_MHZ       40'h00000000C8

// frequency divider reset value: one 64f tick per 200 cycles
`define SGDS_FREQ_RST      24'h0000C8

// test-frequency tick divisor at or above which the sync wait drops to 1/32 period
`define SGDS_LOWF_TICKS    24'h000400

// filter selection thresholds on the tick divisor
`define SGDS_FILT_T1       24'h000040
`define SGDS_FILT_T2       24'h000200
`define SGDS_FILT_T3       24'h001000

`endif

// File: rtl/sgds_sine_rom.v
/*
  64-entry, 8-bit offset-binary sine table read by index.
  assumes a registered consumer; the lookup itself is pure logic.
*/
`timescale 1ns/1ps
`default_nettype none
module sgds_sine_rom (
  // table index
  input  wire [5:0] addr,
  // sample
  output reg  [7:0] data
);
  always @* begin
    case (addr)
      6'h00: data = 8'h80; 6'h01: data = 8'h8C; 6'h02: data = 8'h98; 6'h03: data = 8'hA5;
      6'h04: data = 8'hB0; 6'h05: data = 8'hBC; 6'h06: data = 8'hC6; 6'h07: data = 8'hD0;
      6'h08: data = 8'hDA; 6'h09: data = 8'hE2; 6'h0A: data = 8'hEA; 6'h0B: data = 8'hF0;
      6'h0C: data = 8'hF5; 6'h0D: data = 8'hFA; 6'h0E: data = 8'hFD; 6'h0F: data = 8'hFE;
      6'h10: data = 8'hFF; 6'h11: data = 8'hFE; 6'h12: data = 8'hFD; 6'h13: data = 8'hFA;
      6'h14: data = 8'hF5; 6'h15: data = 8'hF0; 6'h16: data = 8'hEA; 6'h17: data = 8'hE2;
      6'h18: data = 8'hDA; 6'h19: data = 8'hD0; 6'h1A: data = 8'hC6; 6'h1B: data = 8'hBC;
      6'h1C: data = 8'hB0; 6'h1D: data = 8'hA5; 6'h1E: data = 8'h98; 6'h1F: data = 8'h8C;
      6'h20: data = 8'h80; 6'h21: data = 8'h73; 6'h22: data = 8'h67; 6'h23: data = 8'h5A;
      6'h24: data = 8'h4F; 6'h25: data = 8'h43; 6'h26: data = 8'h39; 6'h27: data = 8'h2F;
      6'h28: data = 8'h25; 6'h29: data = 8'h1D; 6'h2A: data = 8'h15; 6'h2B: data = 8'h0F;
      6'h2C: data = 8'h0A; 6'h2D: data = 8'h05; 6'h2E: data = 8'h02; 6'h2F: data = 8'h01;
      6'h30: data = 8'h00; 6'h31: data = 8'h01; 6'h32: data = 8'h02; 6'h33: data = 8'h05;
      6'h34: data = 8'h0A; 6'h35: data = 8'h0F; 6'h36: data = 8'h15; 6'h37: data = 8'h1D;
      6'h38: data = 8'h25; 6'h39: data = 8'h2F; 6'h3A: data = 8'h39; 6'h3B: data = 8'h43;
      6'h3C: data = 8'h4F; 6'h3D: data = 8'h5A; 6'h3E: data = 8'h67; 6'h3F: data = 8'h73;
      default: data = 8'h80;
    endcase
  end
endmodule // sgds_sine_rom
`default_nettype wire

// File: verif/sgds_assertions.sv
/*
  checker for sgds_top: divider stepping, reset state, sampling and
  deintegration ordering.
  assumes bind from tb onto sgds_top, single pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sgds_assertions (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // comparator pins
  input wire logic       zero_cross_flag_n,
  input wire logic       integ_overrange_flag_n,
  // sequencer outputs
  input wire logic [5:0] freq_bits,
  input wire logic       freq_count_clock,
  input wire logic       integ_sample,
  input wire logic       integ_deint
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_FCLK_BIT5: assert property (freq_count_clock == freq_bits[5])
    else $error("count clock differs from divider top bit");
  AST_DIV_STEP: assert property ((freq_bits != $past(freq_bits)) |-> (freq_bits == $past(freq_bits) + 6'h01))
    else $error("divider moved by other than one");
  AST_RESET_STATE: assert property ($rose(presetn) |-> (freq_bits == 6'h00 && !integ_sample && !integ_deint))
    else $error("outputs not idle after reset");
  AST_SAMPLE_CLEAR: assert property ($rose(integ_sample) |-> !integ_deint)
    else $error("sampling began during deintegration");
  AST_DEINT_CAUSE: assert property ($rose(integ_deint) |-> (integ_sample || $past(integ_sample)))
    else $error("deintegration without sampling");
  AST_DEINT_STOP: assert property ((!zero_cross_flag_n) [*6] |-> !integ_deint)
    else $error("deintegration kept after zero crossing");
  AST_OVR_START: assert property (($fell(integ_overrange_flag_n) && integ_sample) |-> ##[1:6] integ_deint)
    else $error("overrange did not start deintegration");
  AST_OVR_KEEP: assert property (($rose(integ_deint) && integ_sample && !integ_overrange_flag_n) |=> integ_sample)
    else $error("sampling stopped on overrange");

  cover property ($rose(integ_sample));
  cover property ($rose(integ_deint) && integ_sample);
  cover property ($fell(integ_deint));
endmodule // sgds_assertions
`default_nettype wire

// File: verif/sgds_integ_model.sv
/*
  integrator and comparator model: charges while sampling, may report
  overrange once, reports zero a fixed time into deintegration, not before sampling ends.
  assumes pin levels are sampled through the block's own synchronisers.
*/
`timescale 1ns/1ps
`default_nettype none
module sgds_integ_model #(
  parameter int DEINT_CYCLES = 40,
  parameter int OVR_DELAY    = 30
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // block side
  input  wire logic integ_sample,
  input  wire logic integ_deint,
  input  wire logic ovr_en,
  // comparator pins
  output var  logic zero_cross_flag_n,
  output var  logic integ_overrange_flag_n
);
  int   scnt;
  int   dcnt;
  logic fired;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_cross_flag_n      <= 1'b0;
      integ_overrange_flag_n <= 1'b1;
      scnt <= 0;
      dcnt <= 0;
      fired <= 1'b0;
    end else if (integ_deint) begin
      integ_overrange_flag_n <= 1'b1;
      dcnt <= dcnt + 1;
      // no zero report while sampling still overlaps: the net charge still rises
      if (dcnt >= DEINT_CYCLES && !integ_sample) zero_cross_flag_n <= 1'b0;
    end else if (integ_sample) begin
      dcnt <= 0;
      scnt <= scnt + 1;
      // one overrange per sampling, so the cap does not recharge forever
      if (!fired) zero_cross_flag_n <= 1'b1;
      if (ovr_en && !fired && scnt == OVR_DELAY) begin
        integ_overrange_flag_n <= 1'b0;
        fired <= 1'b1;
      end
    end else begin
      scnt <= 0;
      dcnt <= 0;
      fired <= 1'b0;
    end
  end
endmodule // sgds_integ_model
`default_nettype wire

// File: verif/tb.sv
/*
  testbench for sgds_top: apb host tasks, reset values, clamping, filter,
  reference phase, integration counts and an overrange conversion.
  assumes sgds_consts.vh and the integrator model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sgds_consts.vh"
module tb;
  logic        pclk, presetn, psel, penable, pwrite, ovr_en, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire  [31:0] prdata;
  wire         pready, pslverr, zc_n, ovr_n, fclk, smp, dei;
  wire  [7:0]  test_dac, ref_dac;
  wire  [1:0]  filter_sel;
  wire  [5:0]  freq_bits;
  int          errors, n_tests, cyc, k, n;
  logic [7:0]  tw [256];
  logic [7:0]  rw [256];
  int          cr [5] = '{0, 0, 1, 2, 0};
  int          cf [5] = '{1, 24, 24, 4, 1};
  int          cq [5] = '{3, 2, 3, 3, 32'h2000};
  int          fv [6] = '{32'h3F, 32'h40, 32'h1FF, 32'h200, 32'hFFF, 32'h1000};

  sgds_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .zero_cross_flag_n(zc_n), .integ_overrange_flag_n(ovr_n), .test_dac(test_dac), .ref_dac(ref_dac),
    .filter_sel(filter_sel), .freq_bits(freq_bits), .freq_count_clock(fclk), .integ_sample(smp),
    .integ_deint(dei));
  sgds_integ_model im (.pclk(pclk), .presetn(presetn), .integ_sample(smp), .integ_deint(dei),
    .ovr_en(ovr_en), .zero_cross_flag_n(zc_n), .integ_overrange_flag_n(ovr_n));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // host side of the converter: every control goes through these cycles
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready ends this wait; the wait has no limit of its own, only the bench timeout
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  function automatic logic [31:0] exp_integ(input int r, input longint f, input longint fq);
    longint b, p, m;
    p = 64 * fq;
    b = (r == 0) ? 200000 * f : (r == 1) ? 835000 * f : 64'd20000000;
    m = (r == 0) ? (2 * b + p) / (2 * p) : b / p;
    return (m < 1) ? 32'h1 : m[31:0];
  endfunction

  function automatic logic [1:0] exp_filt(input int v);
    return (v < `SGDS_FILT_T1) ? 2'h0 : (v < `SGDS_FILT_T2) ? 2'h1 : (v < `SGDS_FILT_T3) ? 2'h2 : 2'h3;
  endfunction

  initial begin
    errors = 0; n_tests = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; ovr_en = 1'b1;
    paddr = 12'h000; pwdata = 32'h0;
    repeat (10) @(posedge pclk);
    check(test_dac, 8'h80);
    check(ref_dac, 8'h80);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, `SGDS_OFF_FREQ, 0);   check(rd, `SGDS_FREQ_RST);
    apb(0, `SGDS_OFF_CTRL, 0);   check(rd, 32'h8);
    apb(0, `SGDS_OFF_FACTOR, 0); check(rd, `SGDS_FACTOR_RST);
    apb(0, 12'h020, 0);          check(rd, 32'h0);
    check(err, 1'b1);
    apb(1, `SGDS_OFF_FACTOR, 0); apb(0, `SGDS_OFF_FACTOR, 0); check(rd, `SGDS_FACTOR_MIN);
    apb(1, `SGDS_OFF_FACTOR, 32'hFF); apb(0, `SGDS_OFF_FACTOR, 0); check(rd, `SGDS_FACTOR_MAX);
    for (int i = 0; i < 6; i++) begin
      apb(1, `SGDS_OFF_FREQ, fv[i]);
      repeat (3) @(posedge pclk);
      check(filter_sel, exp_filt(fv[i]));
    end
    // two pclk per tick: one period is 128 cycles, a quarter is 32
    apb(1, `SGDS_OFF_FREQ, 32'h2);
    for (int p = 0; p < 4; p++) begin
      apb(1, `SGDS_OFF_CTRL, 32'h10 | (p << 5));
      repeat (4) @(posedge pclk);
      for (int c = 0; c < 256; c++) begin
        @(posedge pclk);
        tw[c] = test_dac;
        rw[c] = ref_dac;
      end
      for (int c = 0; c < 128; c++) begin
        check(rw[c], tw[c + 32 * p]);
        check(tw[c], tw[c + 128]);
      end
    end
    n = 0;
    for (int c = 1; c < 129; c++) if (tw[c] !== tw[c - 1]) n++;
    check(n > 32 && n <= 64, 1'b1);
    for (int i = 0; i < 5; i++) begin
      do_reset();
      apb(1, `SGDS_OFF_FREQ, cq[i]);
      apb(1, `SGDS_OFF_FACTOR, cf[i]);
      apb(1, `SGDS_OFF_CTRL, 32'h1 | (cr[i] << 2));
      apb(0, `SGDS_OFF_STATUS, 0); check(rd[1], 1'b1);
      apb(0, `SGDS_OFF_INTEG, 0);  check(rd, exp_integ(cr[i], cf[i], cq[i]));
      do_reset();
      apb(0, `SGDS_OFF_STATUS, 0); check(rd[1], 1'b0);
    end
    // one-period integration: start at a slow divider, then speed it up
    apb(1, `SGDS_OFF_FREQ, 32'h2000);
    apb(1, `SGDS_OFF_FACTOR, 32'h1);
    apb(1, `SGDS_OFF_CTRL, 32'h1);
    apb(1, `SGDS_OFF_FREQ, 32'h2);
    k = 0;
    while (smp !== 1'b1 && k < 400) begin
      @(posedge pclk);
      k++;
    end
    check(k <= 200, 1'b1);
    k = 0;
    while (dei !== 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    check(dei, 1'b1);
    check(smp, 1'b1);
    n = 0;
    while (dei === 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    check(dei, 1'b0);
    repeat (4) @(posedge pclk);
    apb(0, `SGDS_OFF_RESULT, 0);
    check(rd + 1 >= n && rd <= n + 1, 1'b1);
    for (int q = 0; q < 2; q++) begin
      if (q == 1) begin
        apb(1, `SGDS_OFF_FREQ, 32'h2000);
        apb(1, `SGDS_OFF_CTRL, 32'h3);
        apb(1, `SGDS_OFF_FREQ, 32'h2);
      end
      k = 0;
      do begin
        apb(0, `SGDS_OFF_STATUS, 0);
        k++;
      end while (rd[3] !== 1'b1 && k < 1000);
      check(rd[3], 1'b1);
      check(rd[7:4], 5 - q);
    end
    tally_and_finish();
  end
endmodule // tb

bind sgds_top sgds_assertions chk (.pclk(pclk), .presetn(presetn), .zero_cross_flag_n(zero_cross_flag_n),
  .integ_overrange_flag_n(integ_overrange_flag_n), .freq_bits(freq_bits), .freq_count_clock(freq_count_clock),
  .integ_sample(integ_sample), .integ_deint(integ_deint));
`default_nettype wire
